// ### src/rcpc_top.sv
// rcpc_top: register bank for coexistence priorities, link error status,
// signal-strength capture and traffic indication selection.
// assumes an APB master on CLK_SYS; fault, sync and wake inputs are
// one-cycle pulses on CLK_SYS; LP_CLK and RADIO_POWERED are asynchronous.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
module rcpc_top (
	input wire logic CLK_SYS,
	input wire logic RESET,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic RESOLVE_FAULT,
	input wire logic PHYSICAL_FAULT,
	input wire logic SYNC_DETECTED_EVENT,
	input wire logic [9:0] STRENGTH_PEAK_HOLD,
	input wire logic [9:0] STRENGTH_AVERAGE,
	input wire logic LOWPOWER_WAKE_INTERRUPT,
	input wire logic LP_CLK,
	input wire logic RADIO_POWERED,
	input wire logic [3:0] PTI_STATIC,
	input wire logic [3:0] PTI_DYNAMIC,
	output rcpc_pkg::rcpc_prio_t PRIO,
	output rcpc_pkg::rcpc_coex_t COEX,
	output logic [7:0] RX_STRENGTH_FIELD,
	output logic LINK_GENERAL_INTERRUPT,
	output logic LOWPOWER_WAKE_STATUS,
	output logic IRQ
);
	import rcpc_pkg::*;

	if (RAW_STR_W < STR_W + STR_SLICE_LSB || PRIO_W != 4 || THR_W > 8)
	begin : g_bad_cfg
		$error("rcpc_top: field widths out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// bus decode

	logic setup;
	logic access;
	logic wr;
	logic rd_setup;
	logic hit;
	logic [31:0] prdata_q;

	assign setup = PSEL & ~PENABLE;
	assign access = PSEL & PENABLE;
	assign hit = (PADDR == ADDR_PRIO_TABLE) || (PADDR == ADDR_DFLT_PRIO)
		|| (PADDR == ADDR_CTRL_TWO) || (PADDR == ADDR_IRQ_STAT)
		|| (PADDR == ADDR_IRQ_MASK) || (PADDR == ADDR_COEX_THR)
		|| (PADDR == ADDR_RX_STRENGTH);
	assign wr = access & PWRITE & hit;
	assign rd_setup = setup & ~PWRITE;

	// zero wait states; unmapped addresses answer with an error
	assign PREADY = 1'b1;
	assign PSLVERR = access & ~hit;
	assign PRDATA = prdata_q;

	////////////////////////////////////////////////////////////////////////
	// priority registers

	logic [31:0] prio_q;
	logic [3:0] dflt_q;

	for (genvar g = 0; g < DATA_W / PRIO_W; g++)
	begin : g_prio
		always_ff @(posedge CLK_SYS or posedge RESET)
		begin
			if (RESET)
				prio_q[g*PRIO_W +: PRIO_W] <=
					RST_PRIO_TABLE[g*PRIO_W +: PRIO_W];
			else if (wr && PADDR == ADDR_PRIO_TABLE)
				prio_q[g*PRIO_W +: PRIO_W] <= PWDATA[g*PRIO_W +: PRIO_W];
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			dflt_q <= RST_DFLT_PRIO;
		else if (wr && PADDR == ADDR_DFLT_PRIO)
			dflt_q <= PWDATA[DFLT_LSB +: PRIO_W];
	end

	assign PRIO = {prio_q, dflt_q};

	////////////////////////////////////////////////////////////////////////
	// control register two

	logic physical_fault_enable_q;
	logic resolve_error_enable_q;
	logic strength_source_select_q;
	logic [1:0] spare_q;
	logic pti_source_select_q;
	logic ctrl_wr;

	assign ctrl_wr = wr && PADDR == ADDR_CTRL_TWO;

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			physical_fault_enable_q <= 1'b0;
			resolve_error_enable_q <= 1'b0;
			strength_source_select_q <= 1'b0;
			spare_q <= 2'h0;
			pti_source_select_q <= 1'b0;
		end
		else if (ctrl_wr)
		begin
			physical_fault_enable_q <= PWDATA[BIT_PHY_EN];
			resolve_error_enable_q <= PWDATA[BIT_RES_EN];
			strength_source_select_q <= PWDATA[BIT_STR_SEL];
			spare_q <= PWDATA[BIT_SPARE_LO +: 2];
			pti_source_select_q <= PWDATA[BIT_PTI_SEL];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link error status

	logic link_error_status_q;
	logic err_set;

	assign err_set = (RESOLVE_FAULT & resolve_error_enable_q)
		| (PHYSICAL_FAULT & physical_fault_enable_q);

	// write one clears, a new fault wins
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			link_error_status_q <= 1'b0;
		else if (err_set)
			link_error_status_q <= 1'b1;
		else if (ctrl_wr && PWDATA[BIT_ERR_STAT])
			link_error_status_q <= 1'b0;
	end

	assign LINK_GENERAL_INTERRUPT = link_error_status_q;

	////////////////////////////////////////////////////////////////////////
	// signal strength capture

	logic [7:0] rx_strength_field_q;

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			rx_strength_field_q <= 8'h00;
		else if (SYNC_DETECTED_EVENT)
			rx_strength_field_q <= strength_source_select_q
				? STRENGTH_AVERAGE[STR_SLICE_LSB +: STR_W]
				: STRENGTH_PEAK_HOLD[STR_SLICE_LSB +: STR_W];
	end

	assign RX_STRENGTH_FIELD = rx_strength_field_q;

	////////////////////////////////////////////////////////////////////////
	// low power wake-up status

	logic [1:0] async_s;
	logic wake_ack;
	logic lowpower_wake_status_q;

	rcpc_sync2 #(
		.W(2)
	) u_sync (
		.clk(CLK_SYS),
		.rst(RESET),
		.d({LP_CLK, RADIO_POWERED}),
		.q(async_s)
	);

	rcpc_wake_ack u_wake_ack (
		.clk(CLK_SYS),
		.rst(RESET),
		.lp_clk(async_s[1]),
		.powered(async_s[0]),
		.pending(lowpower_wake_status_q),
		.ack(wake_ack)
	);

	// set by wake-up, cleared by hardware ack
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			lowpower_wake_status_q <= 1'b0;
		else if (LOWPOWER_WAKE_INTERRUPT)
			lowpower_wake_status_q <= 1'b1;
		else if (wake_ack)
			lowpower_wake_status_q <= 1'b0;
	end

	assign LOWPOWER_WAKE_STATUS = lowpower_wake_status_q;

	////////////////////////////////////////////////////////////////////////
	// coexistence traffic indication

	logic [THR_W-1:0] rx_thr_q;
	logic [THR_W-1:0] tx_thr_q;
	logic [3:0] pti_sel;
	rcpc_coex_t coex_q;

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
		begin
			rx_thr_q <= '0;
			tx_thr_q <= '0;
		end
		else if (wr && PADDR == ADDR_COEX_THR)
		begin
			rx_thr_q <= PWDATA[RX_THR_LSB +: THR_W];
			tx_thr_q <= PWDATA[TX_THR_LSB +: THR_W];
		end
	end

	assign pti_sel = pti_source_select_q ? PTI_DYNAMIC : PTI_STATIC;

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			coex_q <= '0;
		else
		begin
			coex_q.pti <= pti_sel;
			coex_q.rx_high <= {1'b0, pti_sel} > rx_thr_q;
			coex_q.tx_high <= {1'b0, pti_sel} > tx_thr_q;
		end
	end

	assign COEX = coex_q;

	////////////////////////////////////////////////////////////////////////
	// interrupt status, mask and read data

	logic [IRQ_N-1:0] irq_set;
	logic [IRQ_N-1:0] irq_stat_q;
	logic [IRQ_N-1:0] irq_mask_q;
	logic irq_rd_clr;

	assign irq_set[IRQ_ERR] = err_set;
	assign irq_set[IRQ_WAKE] = LOWPOWER_WAKE_INTERRUPT;
	assign irq_set[IRQ_SYNC] = SYNC_DETECTED_EVENT;
	assign irq_rd_clr = access & ~PWRITE & (PADDR == ADDR_IRQ_STAT);

	// read clears only bits the read returned; set wins
	for (genvar b = 0; b < IRQ_N; b++)
	begin : g_irq
		always_ff @(posedge CLK_SYS or posedge RESET)
		begin
			if (RESET)
				irq_stat_q[b] <= 1'b0;
			else if (irq_set[b])
				irq_stat_q[b] <= 1'b1;
			else if (irq_rd_clr && prdata_q[b])
				irq_stat_q[b] <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			irq_mask_q <= '0;
		else if (wr && PADDR == ADDR_IRQ_MASK)
			irq_mask_q <= PWDATA[IRQ_N-1:0];
	end

	assign IRQ = |(irq_stat_q & irq_mask_q);

	// read data captured in the setup cycle
	always_ff @(posedge CLK_SYS or posedge RESET)
	begin
		if (RESET)
			prdata_q <= '0;
		else if (rd_setup)
		begin
			prdata_q <= '0;
			case (PADDR)
				ADDR_PRIO_TABLE: prdata_q <= prio_q;
				ADDR_DFLT_PRIO: prdata_q[DFLT_LSB +: PRIO_W] <= dflt_q;
				ADDR_CTRL_TWO:
				begin
					prdata_q[BIT_PHY_EN] <= physical_fault_enable_q;
					prdata_q[BIT_RES_EN] <= resolve_error_enable_q;
					prdata_q[BIT_ERR_STAT] <= link_error_status_q;
					prdata_q[BIT_STR_SEL] <= strength_source_select_q;
					prdata_q[BIT_WAKE_STAT] <= lowpower_wake_status_q;
					prdata_q[BIT_SPARE_LO +: 2] <= spare_q;
					prdata_q[BIT_PTI_SEL] <= pti_source_select_q;
				end
				ADDR_IRQ_STAT: prdata_q[IRQ_N-1:0] <= irq_stat_q;
				ADDR_IRQ_MASK: prdata_q[IRQ_N-1:0] <= irq_mask_q;
				ADDR_COEX_THR:
				begin
					prdata_q[RX_THR_LSB +: THR_W] <= rx_thr_q;
					prdata_q[TX_THR_LSB +: THR_W] <= tx_thr_q;
				end
				ADDR_RX_STRENGTH: prdata_q[STR_W-1:0] <= rx_strength_field_q;
				default: prdata_q <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (RESET);

	sequence s_ctrl_write;
		access && PWRITE && PADDR == ADDR_CTRL_TWO;
	endsequence

	sequence s_ctrl_read;
		setup && !PWRITE && PADDR == ADDR_CTRL_TWO ##1 access;
	endsequence

	a_prio_update: assert property (
		access && PWRITE && PADDR == ADDR_PRIO_TABLE
		|=> PRIO[PRIO_W +: DATA_W] == $past(PWDATA))
		else $error("priority table not updated by write");

	a_prio_hold: assert property (
		!(access && PWRITE && PADDR == ADDR_PRIO_TABLE)
		|=> $stable(prio_q))
		else $error("priority table changed without write");

	a_dflt_update: assert property (
		access && PWRITE && PADDR == ADDR_DFLT_PRIO
		|=> PRIO.prio_other_default == $past(PWDATA[DFLT_LSB +: PRIO_W]))
		else $error("default priority not updated");

	a_err_masked: assert property (
		!resolve_error_enable_q && !PHYSICAL_FAULT && !LINK_GENERAL_INTERRUPT
		|=> !LINK_GENERAL_INTERRUPT)
		else $error("masked fault raised the error interrupt");

	a_err_raise: assert property (
		(RESOLVE_FAULT && resolve_error_enable_q)
		|| (PHYSICAL_FAULT && physical_fault_enable_q)
		|=> LINK_GENERAL_INTERRUPT)
		else $error("enabled fault did not set error status");

	a_err_w1c: assert property (
		s_ctrl_write ##0 PWDATA[BIT_ERR_STAT] && !err_set
		|=> !LINK_GENERAL_INTERRUPT)
		else $error("write one did not clear error status");

	a_err_w0: assert property (
		s_ctrl_write ##0 !PWDATA[BIT_ERR_STAT] && LINK_GENERAL_INTERRUPT
		|=> LINK_GENERAL_INTERRUPT)
		else $error("write zero disturbed error status");

	a_strength_pick: assert property (
		SYNC_DETECTED_EVENT |=> RX_STRENGTH_FIELD == ($past(
		strength_source_select_q) ? $past(STRENGTH_AVERAGE[9:2])
		: $past(STRENGTH_PEAK_HOLD[9:2])))
		else $error("captured strength from wrong source");

	a_wake_read: assert property (
		s_ctrl_read |-> PRDATA[BIT_WAKE_STAT] == $past(LOWPOWER_WAKE_STATUS))
		else $error("wake status readback wrong");

	a_wake_hold: assert property (
		LOWPOWER_WAKE_STATUS && !async_s[0] |=> LOWPOWER_WAKE_STATUS)
		else $error("wake status cleared before power-up");

	a_pti_source: assert property (
		1'b1 |=> COEX.pti == ($past(pti_source_select_q)
		? $past(PTI_DYNAMIC) : $past(PTI_STATIC)))
		else $error("wrong traffic indication source");

	a_rx_high: assert property (
		{1'b0, pti_sel} > rx_thr_q ##1 1'b1 |-> COEX.rx_high)
		else $error("rx high priority not flagged");

	a_tx_high: assert property (
		{1'b0, pti_sel} <= tx_thr_q |=> !COEX.tx_high)
		else $error("tx high priority flagged below threshold");

	a_rsvd_zero: assert property (
		s_ctrl_read |-> PRDATA[31:25] == 7'h00)
		else $error("reserved bits of control two not zero");

	a_irq_level: assert property (
		(|(irq_set & irq_mask_q) && !(wr && PADDR == ADDR_IRQ_MASK))
		|| (wr && PADDR == ADDR_IRQ_MASK
		&& |(PWDATA[IRQ_N-1:0] & irq_stat_q))
		|=> IRQ)
		else $error("unmasked status did not raise the interrupt");

endmodule

// ### src/rcpc_pkg.sv
// rcpc_pkg: register map, reset values, field positions and carrier types
// of the radio coexistence priority control block.
// assumes a 32-bit APB with byte addresses and one word per register.
package rcpc_pkg;

	localparam int DATA_W = 32;
	localparam int PRIO_W = 4;
	localparam int RAW_STR_W = 10;
	localparam int STR_W = 8;
	localparam int THR_W = 5;
	localparam int IRQ_N = 3;

	localparam logic [31:0] ADDR_PRIO_TABLE = 32'h40000108;
	localparam logic [31:0] ADDR_DFLT_PRIO = 32'h4000010C;
	localparam logic [31:0] ADDR_CTRL_TWO = 32'h40000200;
	localparam logic [31:0] ADDR_IRQ_STAT = 32'h40000210;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'h40000214;
	localparam logic [31:0] ADDR_COEX_THR = 32'h40000218;
	localparam logic [31:0] ADDR_RX_STRENGTH = 32'h4000021C;

	localparam logic [31:0] RST_PRIO_TABLE = 32'h3489ADEF;
	localparam logic [3:0] RST_DFLT_PRIO = 4'h3;
	localparam int DFLT_LSB = 28;

	// control register two layout
	localparam int BIT_PHY_EN = 24;
	localparam int BIT_RES_EN = 23;
	localparam int BIT_ERR_STAT = 22;
	localparam int BIT_STR_SEL = 21;
	localparam int BIT_WAKE_STAT = 20;
	localparam int BIT_SPARE_LO = 18;
	localparam int BIT_PTI_SEL = 17;
	localparam int STR_SLICE_LSB = 2;

	// coexistence threshold register layout
	localparam int RX_THR_LSB = 24;
	localparam int TX_THR_LSB = 16;

	// interrupt status and mask layout
	localparam int IRQ_ERR = 0;
	localparam int IRQ_WAKE = 1;
	localparam int IRQ_SYNC = 2;

	typedef struct packed {
		logic [3:0] prio_passive_scan;
		logic [3:0] prio_nonconn_adv;
		logic [3:0] prio_conn_adv;
		logic [3:0] prio_active_scan;
		logic [3:0] prio_init_scan;
		logic [3:0] prio_data_channel;
		logic [3:0] prio_link_ctrl_proc;
		logic [3:0] prio_conn_req_resp;
		logic [3:0] prio_other_default;
	} rcpc_prio_t;

	typedef struct packed {
		logic [3:0] pti;
		logic rx_high;
		logic tx_high;
	} rcpc_coex_t;

	typedef enum {WK_IDLE, WK_ALIGN, WK_PERIOD} rcpc_wake_st_t;

endpackage

// ### src/rcpc_sync2.sv
// rcpc_sync2: two flip-flop synchroniser for slow levels.
// assumes each bit is an independent level from another domain.
`timescale 1ns/1ps
module rcpc_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			meta_q <= '0;
			q <= '0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule

// ### src/rcpc_wake_ack.sv
// rcpc_wake_ack: times the automatic acknowledge of the wake-up status.
// assumes lp_clk and powered are already synchronised to clk.
`timescale 1ns/1ps
module rcpc_wake_ack
	import rcpc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic lp_clk,
	input wire logic powered,
	input wire logic pending,
	output logic ack
);
	rcpc_wake_st_t st_q;
	logic lp_prev_q;
	logic lp_rise;

	assign lp_rise = lp_clk & ~lp_prev_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			lp_prev_q <= 1'b0;
		else
			lp_prev_q <= lp_clk;
	end

	// first rising edge aligns, the next closes one full period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			st_q <= WK_IDLE;
		else if (!pending || !powered)
			st_q <= WK_IDLE;
		else
		begin
			case (st_q)
				WK_IDLE: st_q <= WK_ALIGN;
				WK_ALIGN: if (lp_rise) st_q <= WK_PERIOD;
				WK_PERIOD: if (lp_rise) st_q <= WK_IDLE;
				default: st_q <= WK_IDLE;
			endcase
		end
	end

	assign ack = pending & powered & (st_q == WK_PERIOD) & lp_rise;
endmodule

// ### verification/rcpc_top_tb.sv
// rcpc_top_tb: self-checking bench for the coexistence priority register bank.
// assumes zero-wait APB answers and one-cycle event pulses on clk.
`timescale 1ns/1ps
module rcpc_top_tb;
	import rcpc_pkg::*;

	typedef struct {logic [31:0] data; logic err;} rcpc_note_t;

	logic clk, rst, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, v;
	logic res_f, phy_f, sync_ev, wake_ev, lp_clk, powered;
	logic [9:0] peak, avg;
	logic [3:0] pti_s, pti_d, pe;
	logic [7:0] rx_str, se;
	logic gen_irq, wake_st, irq;
	rcpc_prio_t prio;
	rcpc_coex_t coex;
	rcpc_note_t notes[$];
	rcpc_note_t nt;
	logic [31:0] lfsr_q = 32'h2AAD64B6;
	int n_errors = 0;
	int checked = 0;
	int cyc = 0;
	int n;

	rcpc_top u_dut (.CLK_SYS(clk), .RESET(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.RESOLVE_FAULT(res_f), .PHYSICAL_FAULT(phy_f),
		.SYNC_DETECTED_EVENT(sync_ev), .STRENGTH_PEAK_HOLD(peak),
		.STRENGTH_AVERAGE(avg), .LOWPOWER_WAKE_INTERRUPT(wake_ev),
		.LP_CLK(lp_clk), .RADIO_POWERED(powered), .PTI_STATIC(pti_s),
		.PTI_DYNAMIC(pti_d), .PRIO(prio), .COEX(coex),
		.RX_STRENGTH_FIELD(rx_str), .LINK_GENERAL_INTERRUPT(gen_irq),
		.LOWPOWER_WAKE_STATUS(wake_st), .IRQ(irq));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [31:0] rnd();
		lfsr_q = {lfsr_q[30:0],
			lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q;
	endfunction

	// one transfer from setup to the edge that samples pready
	task automatic apb(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		apb(1'b1, a, d);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e,
		input logic err = 1'b0);
		notes.push_back('{e, err});
		@(posedge clk);
		apb(1'b0, a, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// mask order: resolve, physical, sync, wake
	task automatic pulse(input logic [3:0] m);
		@(posedge clk);
		{res_f, phy_f, sync_ev, wake_ev} <= m;
		@(posedge clk);
		{res_f, phy_f, sync_ev, wake_ev} <= 4'h0;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// free-running low power clock, sixteen system cycles a period
	initial
	begin
		lp_clk = 1'b0;
		forever
		begin
			repeat (8) @(posedge clk);
			lp_clk <= ~lp_clk;
		end
	end

	// read monitor: oldest note against data taken at the access edge
	always @(posedge clk)
		if (psel && penable && pready && !pwrite)
		begin
			if (notes.size() == 0)
				chk("read note count", 32'h1, 32'h0);
			else
			begin
				nt = notes.pop_front();
				chk("prdata", nt.data, prdata);
				chk("pslverr", {31'h0, nt.err}, {31'h0, pslverr});
			end
		end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 6000)
		begin
			n_errors++;
			summarize();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{res_f, phy_f, sync_ev, wake_ev, powered} = '0;
		{peak, avg, pti_s, pti_d} = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("prio table", RST_PRIO_TABLE, prio[35:4]);
		chk("default prio", {28'h0, RST_DFLT_PRIO}, {28'h0, prio[3:0]});
		rd(ADDR_PRIO_TABLE, RST_PRIO_TABLE);
		rd(ADDR_DFLT_PRIO, 32'h30000000);
		rd(ADDR_CTRL_TWO, 32'h0);
		$display("test reset values done");

		v = rnd();
		notes.push_back('{v, 1'b0});
		@(posedge clk);
		apb(1'b1, ADDR_PRIO_TABLE, v);
		apb(1'b0, ADDR_PRIO_TABLE, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
		chk("prio table", v, prio[35:4]);
		wr(ADDR_DFLT_PRIO, 32'hFFFFFFFF);
		rd(ADDR_DFLT_PRIO, 32'hF0000000);
		@(negedge clk);
		chk("default prio", 32'hF, {28'h0, prio[3:0]});
		wr(ADDR_CTRL_TWO, 32'hFFFFFFFF);
		rd(ADDR_CTRL_TWO, 32'h01AE0000);
		wr(ADDR_CTRL_TWO, 32'h0);
		$display("test priority writes done");

		pulse(4'hC);
		@(negedge clk);
		chk("error interrupt", 32'h0, {31'h0, gen_irq});
		wr(ADDR_CTRL_TWO, 32'h00800000);
		pulse(4'h4);
		@(negedge clk);
		chk("error interrupt", 32'h0, {31'h0, gen_irq});
		pulse(4'h8);
		@(negedge clk);
		chk("error interrupt", 32'h1, {31'h0, gen_irq});
		rd(ADDR_CTRL_TWO, 32'h00C00000);
		wr(ADDR_CTRL_TWO, 32'h00800000);
		@(negedge clk);
		chk("error interrupt", 32'h1, {31'h0, gen_irq});
		wr(ADDR_CTRL_TWO, 32'h00C00000);
		@(negedge clk);
		chk("error interrupt", 32'h0, {31'h0, gen_irq});
		wr(ADDR_CTRL_TWO, 32'h01000000);
		pulse(4'h8);
		@(negedge clk);
		chk("error interrupt", 32'h0, {31'h0, gen_irq});
		pulse(4'h4);
		@(negedge clk);
		chk("error interrupt", 32'h1, {31'h0, gen_irq});
		wr(ADDR_CTRL_TWO, 32'h01400000);
		@(negedge clk);
		chk("error interrupt", 32'h0, {31'h0, gen_irq});
		wr(ADDR_CTRL_TWO, 32'h0);
		$display("test link error done");

		for (int s = 0; s < 2; s++)
		begin
			wr(ADDR_CTRL_TWO, (s == 1) ? 32'h00200000 : 32'h0);
			v = rnd();
			se = (s == 1) ? v[25:18] : v[9:2];
			@(posedge clk);
			peak <= v[9:0];
			avg <= v[25:16];
			pulse(4'h2);
			@(negedge clk);
			chk("rx strength", {24'h0, se}, {24'h0, rx_str});
			rd(ADDR_RX_STRENGTH, {24'h0, se});
		end
		$display("test strength capture done");

		wr(ADDR_COEX_THR, 32'h05070000);
		rd(ADDR_COEX_THR, 32'h05070000);
		for (int s = 0; s < 2; s++)
		begin
			wr(ADDR_CTRL_TWO, (s == 1) ? 32'h00020000 : 32'h0);
			for (int p = 0; p < 16; p++)
			begin
				pe = (s == 1) ? 4'(15 - p) : 4'(p);
				@(posedge clk);
				pti_s <= 4'(p);
				pti_d <= 4'(15 - p);
				@(posedge clk);
				@(negedge clk);
				chk("coex", {26'h0, pe, pe > 4'h5, pe > 4'h7}, {26'h0, coex});
			end
		end
		wr(ADDR_CTRL_TWO, 32'h0);
		$display("test traffic indication done");

		pulse(4'h1);
		@(negedge clk);
		chk("wake status", 32'h1, {31'h0, wake_st});
		rd(ADDR_CTRL_TWO, 32'h00100000);
		repeat (40) @(posedge clk);
		@(negedge clk);
		chk("wake status", 32'h1, {31'h0, wake_st});
		@(posedge clk);
		powered <= 1'b1;
		n = 0;
		// watch the wake status output each cycle until it drops, for at most 80 cycles
		while (wake_st === 1'b1 && n < 80)
		begin
			@(posedge clk);
			n++;
		end
		chk("wake ack window", 32'h1, {31'h0, n >= 16 && n <= 45});
		rd(ADDR_CTRL_TWO, 32'h0);
		$display("test wake acknowledge done");

		wr(ADDR_IRQ_MASK, 32'h0);
		rd(ADDR_IRQ_STAT, 32'h7);
		rd(ADDR_IRQ_STAT, 32'h0);
		wr(ADDR_IRQ_MASK, 32'h2);
		rd(ADDR_IRQ_MASK, 32'h2);
		pulse(4'h2);
		@(negedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(ADDR_IRQ_MASK, 32'h4);
		@(negedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		rd(ADDR_IRQ_STAT, 32'h4);
		@(negedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		wr(32'h40000220, 32'hFFFFFFFF);
		rd(32'h40000220, 32'h0, 1'b1);
		@(posedge clk);
		$display("test interrupts done");
		summarize();
	end

endmodule
